/* design/dbcu_pkg.sv */
package dbcu_pkg;

	localparam logic [7:0] DBCU_CMD_VERSION   = 8'h00;
	localparam logic [7:0] DBCU_CMD_STATUS    = 8'h02;
	localparam logic [7:0] DBCU_CMD_RUNCNT    = 8'h03;
	localparam logic [7:0] DBCU_CMD_WR_CTL    = 8'h04;
	localparam logic [7:0] DBCU_CMD_RD_CTL    = 8'h05;
	localparam logic [7:0] DBCU_CMD_WR_PC     = 8'h06;
	localparam logic [7:0] DBCU_CMD_RD_PC     = 8'h07;
	localparam logic [7:0] DBCU_CMD_WR_REG    = 8'h08;
	localparam logic [7:0] DBCU_CMD_RD_REG    = 8'h09;
	localparam logic [7:0] DBCU_CMD_WR_PMEM   = 8'h0A;
	localparam logic [7:0] DBCU_CMD_RD_PMEM   = 8'h0B;
	localparam logic [7:0] DBCU_CMD_WR_DMEM   = 8'h0C;
	localparam logic [7:0] DBCU_CMD_RD_DMEM   = 8'h0D;
	localparam logic [7:0] DBCU_CMD_RD_CRC    = 8'h0E;
	localparam logic [7:0] DBCU_CMD_STEP      = 8'h10;
	localparam logic [7:0] DBCU_CMD_STUFF     = 8'h11;
	localparam logic [7:0] DBCU_CMD_EXEC      = 8'h12;

	localparam logic [7:0] DBCU_BREAK_OPCODE  = 8'h00;
	localparam logic [7:0] DBCU_ACK_CHAR      = 8'hFF;
	localparam logic [7:0] DBCU_CTL_RESET     = 8'h00;
	localparam logic [15:0] DBCU_CNT_ZERO     = 16'h0000;
	localparam logic [15:0] DBCU_CNT_MAX      = 16'hFFFF;

	localparam int DBCU_HALT_BIT              = 7;
	localparam int DBCU_BREAK_ENABLE_FLAG_BIT             = 6;
	localparam int DBCU_ACK_BIT               = 5;
	localparam int DBCU_RST_BIT               = 0;
	localparam logic [7:0] DBCU_CTL_WR_MASK   = 8'hE1;

	// Command classes; declared, but no decoder function returns them.
	typedef enum logic [2:0] {
		DBCU_CLS_NOP,
		DBCU_CLS_LOCAL,
		DBCU_CLS_CORE,
		DBCU_CLS_REGWR
	} dbcu_cls_type;

	// Core-side command: allowed in halted state unless read-protected.
	function automatic logic dbcu_is_core(input logic [7:0] c);
		return (c >= DBCU_CMD_WR_PC && c <= DBCU_CMD_RD_CRC && c != DBCU_CMD_WR_REG)
			|| (c >= DBCU_CMD_STEP && c <= DBCU_CMD_EXEC);
	endfunction

	// Core commands blocked while read protection is programmed.
	function automatic logic dbcu_is_protected(input logic [7:0] c);
		return c == DBCU_CMD_WR_PC || c == DBCU_CMD_RD_PC || c == DBCU_CMD_RD_REG
			|| c == DBCU_CMD_WR_PMEM || c == DBCU_CMD_RD_PMEM || c == DBCU_CMD_WR_DMEM
			|| c == DBCU_CMD_STEP || c == DBCU_CMD_STUFF || c == DBCU_CMD_EXEC;
	endfunction

endpackage

/* design/dbcu_run_counter.sv */
`timescale 1ns/1ns
// ============================================================
// Runtime cycle counter
module dbcu_run_counter #(
	parameter int WIDTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             halted,
	input  wire logic             restart,
	input  wire logic             load_en,
	input  wire logic [WIDTH-1:0] load_value,
	output logic      [WIDTH-1:0] count
);
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] count_d;

	always_comb begin
		count_d = count_q;
		if (restart) begin
			count_d = '0;
		end else if (load_en) begin
			count_d = load_value;
		end else if (!halted && count_q != {WIDTH{1'b1}}) begin
			count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
endmodule // dbcu_run_counter

/* design/dbcu_unit.sv */
`timescale 1ns/1ns
module dbcu_unit
	import dbcu_pkg::*;
#(
	parameter logic [15:0] VERSION = 16'h0100 // Arbitrary value.
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        break_decoded,
	input  wire logic        read_protect_option,
	input  wire logic [7:0]  debugger_status_reg,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        tx_ready,
	input  wire logic        core_done,
	input  wire logic        regwr_flash_ok,
	input  wire logic        cnt_load,
	input  wire logic [15:0] cnt_load_value,
	output logic             tx_valid,
	output logic [7:0]       tx_byte,
	output logic             core_cmd_valid,
	output logic [7:0]       core_cmd,
	output logic             regwr_allowed,
	output logic [7:0]       debugger_control_reg,
	output logic             halted_state_flag,
	output logic             fetch_stop,
	output logic             reset_request,
	output logic [15:0]      run_cycle_counter
);
	import dbcu_pkg::*;

	// ============================================================
	// Command sequencer
	typedef enum {
		ST_IDLE,
		ST_CTL_DATA,
		ST_SEND_HI,
		ST_SEND_LO,
		ST_CORE
	} dbcu_state_type;

	dbcu_state_type state_q, state_d;
	logic [7:0]     ctl_q, ctl_d;
	logic [7:0]     lo_q, lo_d;
	logic [7:0]     txb_q, txb_d;
	logic           txv_q, txv_d;
	logic           corev_q, corev_d;
	logic [7:0]     corec_q, corec_d;
	logic           rwa_q, rwa_d;
	logic           ackp_q, ackp_d;
	logic           rst_q, rst_d;
	logic           cnt_q, restart;
	logic [15:0]    cnt_val;
	logic           halted;
	logic           brk_hit;

	assign halted  = ctl_q[DBCU_HALT_BIT];
	assign brk_hit = break_decoded && ctl_q[DBCU_BREAK_ENABLE_FLAG_BIT] && !halted;

	always_comb begin
		state_d = state_q;
		ctl_d   = ctl_q;
		lo_d    = lo_q;
		txb_d   = txb_q;
		txv_d   = txv_q;
		corev_d = 1'b0;
		corec_d = corec_q;
		rwa_d   = rwa_q;
		ackp_d  = ackp_q;
		rst_d   = 1'b0;
		if (txv_q && tx_ready) begin
			txv_d = 1'b0;
		end
		if (brk_hit) begin
			ctl_d[DBCU_HALT_BIT] = 1'b1;
			if (ctl_q[DBCU_ACK_BIT]) begin
				ackp_d = 1'b1;
			end
		end
		case (state_q)
		ST_IDLE: begin
			if (ackp_q && !txv_d) begin
				txb_d  = DBCU_ACK_CHAR;
				txv_d  = 1'b1;
				ackp_d = brk_hit && ctl_q[DBCU_ACK_BIT];
			end else if (rx_valid && !txv_q) begin
				case (rx_byte)
				DBCU_CMD_VERSION: begin
					txb_d   = VERSION[15:8];
					txv_d   = 1'b1;
					lo_d    = VERSION[7:0];
					state_d = ST_SEND_LO;
				end
				DBCU_CMD_STATUS: begin
					txb_d = debugger_status_reg;
					txv_d = 1'b1;
				end
				DBCU_CMD_RD_CTL: begin
					txb_d = ctl_q;
					txv_d = 1'b1;
				end
				DBCU_CMD_WR_CTL: begin
					state_d = ST_CTL_DATA;
				end
				DBCU_CMD_RUNCNT: begin
					if (halted) begin
						txb_d   = cnt_val[15:8];
						txv_d   = 1'b1;
						lo_d    = cnt_val[7:0];
						state_d = ST_SEND_LO;
					end
				end
				DBCU_CMD_WR_REG: begin
					if (halted) begin
						rwa_d   = !read_protect_option;
						corev_d = 1'b1;
						corec_d = rx_byte;
						state_d = ST_CORE;
					end
				end
				default: begin
					if (halted && dbcu_is_core(rx_byte)
						&& !(read_protect_option && dbcu_is_protected(rx_byte))) begin
						rwa_d   = 1'b0;
						corev_d = 1'b1;
						corec_d = rx_byte;
						state_d = ST_CORE;
					end
				end
				endcase
			end
		end
		ST_CTL_DATA: begin
			if (rx_valid) begin
				ctl_d = rx_byte & DBCU_CTL_WR_MASK;
				if (read_protect_option && halted) begin
					ctl_d[DBCU_HALT_BIT] = 1'b1;
				end
				if (brk_hit) begin
					ctl_d[DBCU_HALT_BIT] = 1'b1;
				end
				rst_d   = rx_byte[DBCU_RST_BIT];
				state_d = ST_IDLE;
			end
		end
		ST_SEND_LO: begin
			if (!txv_d) begin
				txb_d   = lo_q;
				txv_d   = 1'b1;
				state_d = ST_IDLE;
			end
		end
		ST_CORE: begin
			if (core_done) begin
				rwa_d   = 1'b0;
				state_d = ST_IDLE;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			ctl_q   <= DBCU_CTL_RESET;
			lo_q    <= '0;
			txb_q   <= '0;
			txv_q   <= 1'b0;
			corev_q <= 1'b0;
			corec_q <= '0;
			rwa_q   <= 1'b0;
			ackp_q  <= 1'b0;
			rst_q   <= 1'b0;
			cnt_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			ctl_q   <= ctl_d;
			lo_q    <= lo_d;
			txb_q   <= txb_d;
			txv_q   <= txv_d;
			corev_q <= corev_d;
			corec_q <= corec_d;
			rwa_q   <= rwa_d;
			ackp_q  <= ackp_d;
			rst_q   <= rst_d;
			cnt_q   <= ctl_d[DBCU_HALT_BIT];
		end
	end

	// A falling halt bit marks leaving the halted state.
	assign restart = cnt_q && !ctl_d[DBCU_HALT_BIT] && halted;

	// ============================================================
	// Runtime counter
	dbcu_run_counter #(
		.WIDTH      (16)
	) u_cnt (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.halted     (halted),
		.restart    (restart),
		.load_en    (cnt_load && state_q == ST_CORE),
		.load_value (cnt_load_value),
		.count      (cnt_val)
	);

	assign tx_valid             = txv_q;
	assign tx_byte              = txb_q;
	assign core_cmd_valid       = corev_q;
	assign core_cmd             = corec_q;
	assign regwr_allowed        = rwa_q;
	assign debugger_control_reg = ctl_q;
	assign halted_state_flag    = ctl_q[DBCU_HALT_BIT];
	assign fetch_stop           = ctl_q[DBCU_HALT_BIT];
	assign reset_request        = rst_q;
	assign run_cycle_counter    = cnt_val;
endmodule // dbcu_unit

/* tb/dbcu_unit_assertions.sv */
`timescale 1ns/1ns
// ====================
// Port checker
module dbcu_chk (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic        break_decoded,
	input wire logic        read_protect_option,
	input wire logic        rx_valid,
	input wire logic        tx_ready,
	input wire logic        cnt_load,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_byte,
	input wire logic        core_cmd_valid,
	input wire logic [7:0]  core_cmd,
	input wire logic        regwr_allowed,
	input wire logic [7:0]  debugger_control_reg,
	input wire logic        halted_state_flag,
	input wire logic        fetch_stop,
	input wire logic [15:0] run_cycle_counter
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic        h = halted_state_flag;
	wire logic [15:0] c = run_cycle_counter;
	halt_flags_a: assert property (fetch_stop == h && h == debugger_control_reg[7])
		else $error("halt flags differ");
	break_halt_a: assert property (break_decoded && debugger_control_reg[6] |=> h)
		else $error("break did not halt");
	break_off_a: assert property (break_decoded && !debugger_control_reg[6] && !h && !rx_valid
		|=> !h) else $error("disabled break halted");
	cnt_stop_a: assert property ((h && !cnt_load)[*2] ##1 h |-> $stable(c))
		else $error("counter moved while halted");
	cnt_run_a: assert property ((!h && !cnt_load && c != 16'hFFFF)[*3] ##1 !h
		|-> c == $past(c) + 16'h0001) else $error("counter did not count");
	cnt_sat_a: assert property (c == 16'hFFFF && !cnt_load && !h |=> c == 16'hFFFF)
		else $error("counter wrapped");
	tx_stand_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("reply byte dropped");
	core_run_a: assert property (core_cmd_valid |-> h)
		else $error("core command while running");
	core_prot_a: assert property (core_cmd_valid && read_protect_option |-> !(core_cmd inside
		{8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h10, 8'h11, 8'h12}))
		else $error("protected command passed");
	prot_keep_a: assert property (read_protect_option && h |=> h)
		else $error("halt cleared under protection");
	regwr_lim_a: assert property (regwr_allowed |-> !read_protect_option)
		else $error("free register write under protection");
	cover property (core_cmd_valid && read_protect_option);
	cover property (c == 16'hFFFF);
	cover property (tx_valid && tx_byte == 8'hFF);
endmodule // dbcu_chk

/* tb/dbcu_host.sv */
`timescale 1ns/1ns
// ====================
// Slow host: takes each reply byte after a three-cycle stall.
module dbcu_host (
	input wire logic       sys_clk,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_byte,
	output logic           tx_ready
);
	logic [1:0] wait_q = 2'h0;
	logic [7:0] got[0:3];
	int         n_got = 0;
	assign tx_ready = wait_q == 2'h3;
	always @(posedge sys_clk) begin
		wait_q <= (tx_valid && !tx_ready) ? wait_q + 2'h1 : 2'h0;
		if (tx_valid && tx_ready) begin
			got[n_got[1:0]] <= tx_byte;
			n_got <= n_got + 1;
		end
	end
endmodule // dbcu_host

/* tb/tb_debug_break_and_command_unit.sv */
`timescale 1ns/1ns
// ====================
// Bench
module tb_debug_break_and_command_unit;
	import dbcu_pkg::*;
	typedef struct packed {logic [7:0] cmd; int n; logic [15:0] rep;} dbcu_row_type;
	localparam logic [15:0] VER = 16'h2A5C; // Arbitrary value.
	logic sys_clk = 1'b0, sys_rst = 1'b1, break_decoded = 1'b0, read_protect_option = 1'b0;
	logic rx_valid = 1'b0, core_done = 1'b0, cnt_load = 1'b0, regwr_flash_ok = 1'b0;
	logic [7:0]  rx_byte = 8'h00, debugger_status_reg = 8'h96;
	logic [15:0] cnt_load_value = 16'h0000;
	logic        tx_ready, tx_valid, core_cmd_valid, regwr_allowed, halted_state_flag;
	logic        fetch_stop, reset_request;
	logic [7:0]  tx_byte, core_cmd, debugger_control_reg;
	logic [15:0] run_cycle_counter;
	int          errors = 0, n_tests = 0, n_core = 0, n_rst = 0, nb = 0, k, i;
	logic [7:0]  last_core = 8'h00;
	dbcu_row_type rows[10] = '{'{8'h00, 2, VER}, '{8'h02, 1, 16'h9600}, '{8'h05, 1, 16'h0000},
		'{8'h01, 0, 0}, '{8'h0F, 0, 0}, '{8'h13, 0, 0}, '{8'hFF, 0, 0}, '{8'h03, 0, 0},
		'{8'h06, 0, 0}, '{8'h10, 0, 0}};
	always #2 sys_clk = ~sys_clk;
	dbcu_unit #(.VERSION(VER)) dut_u (.*);
	dbcu_host host_u (.sys_clk(sys_clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_ready(tx_ready));
	always @(posedge sys_clk) begin
		if (core_cmd_valid === 1'b1) begin
			n_core++;
			last_core = core_cmd;
		end
		if (reset_request === 1'b1) n_rst++;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge sys_clk);
		rx_valid <= 1'b1;
		rx_byte <= b;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		repeat (20) @(posedge sys_clk);
		// Results are read at the falling edge, once the outputs have settled.
		@(negedge sys_clk);
	endtask
	task automatic strobe(input bit break_opcode);
		@(posedge sys_clk);
		if (break_opcode) break_decoded <= 1'b1;
		else core_done <= 1'b1;
		@(posedge sys_clk);
		break_decoded <= 1'b0;
		core_done <= 1'b0;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(negedge sys_clk);
		check(16'({debugger_control_reg, 7'h00, halted_state_flag}), 16'h0000);
		strobe(1);
		check(16'(halted_state_flag), 16'h0000);
		foreach (rows[j]) begin
			nb = host_u.n_got;
			k = n_core;
			send(rows[j].cmd);
			check(16'(host_u.n_got - nb), 16'(rows[j].n));
			if (rows[j].n > 0) check(16'(host_u.got[nb[1:0]]), 16'(rows[j].rep[15:8]));
			if (rows[j].n > 1) check(16'(host_u.got[2'(nb + 1)]), 16'(rows[j].rep[7:0]));
			check(16'(n_core - k), 16'h0000);
		end
		send(DBCU_CMD_WR_CTL);
		send(8'h60);
		check(16'(debugger_control_reg), 16'h0060);
		nb = host_u.n_got;
		strobe(1);
		check(16'({fetch_stop, halted_state_flag, host_u.got[nb[1:0]]}), 16'h03FF);
		send(DBCU_CMD_WR_CTL);
		send(8'h60);
		for (i = 0; i < 70000 && run_cycle_counter !== 16'hFFFF; i++) @(negedge sys_clk);
		check(16'(i > 65400 && i < 65535), 16'h0001);
		nb = host_u.n_got;
		strobe(1);
		send(DBCU_CMD_RUNCNT);
		check(16'(host_u.n_got - nb), 16'h0003);
		check({host_u.got[2'(nb + 1)], host_u.got[2'(nb + 2)]}, 16'hFFFF);
		k = n_core;
		send(DBCU_CMD_WR_PC);
		check(16'(n_core - k), 16'h0001);
		@(posedge sys_clk);
		cnt_load <= 1'b1;
		cnt_load_value <= 16'h1234;
		@(posedge sys_clk);
		cnt_load <= 1'b0;
		strobe(0);
		nb = host_u.n_got;
		send(DBCU_CMD_RUNCNT);
		check({host_u.got[nb[1:0]], host_u.got[2'(nb + 1)]}, 16'h1234);
		send(DBCU_CMD_WR_REG);
		check(16'({n_core[7:0] - k[7:0], 7'h00, regwr_allowed}), 16'h0201);
		strobe(0);
		@(posedge sys_clk);
		read_protect_option <= 1'b1;
		send(DBCU_CMD_WR_PC);
		check(16'(n_core - k), 16'h0002);
		send(DBCU_CMD_RD_DMEM);
		check(16'(n_core - k), 16'h0003);
		check(16'(last_core), 16'(DBCU_CMD_RD_DMEM));
		strobe(0);
		send(DBCU_CMD_WR_REG);
		check(16'({n_core[7:0] - k[7:0], 7'h00, regwr_allowed}), 16'h0400);
		strobe(0);
		send(DBCU_CMD_WR_CTL);
		send(8'h00);
		check(16'(halted_state_flag), 16'h0001);
		send(DBCU_CMD_WR_CTL);
		send(8'h01);
		check({debugger_control_reg, n_rst[7:0]}, 16'h8101);
		// A reset in mid-run is the only way out of a protected halt.
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(negedge sys_clk);
		check({debugger_control_reg, 7'h00, halted_state_flag}, 16'h0000);
		check(run_cycle_counter, 16'h0000);
		report_and_stop();
	end
endmodule // tb_debug_break_and_command_unit
bind dbcu_unit dbcu_chk chk_u (.*);
